/* logic/pca_pkg.sv */
// pca_pkg: register map, field layout, bus and state types of the power control bank
// assumes a classic wishbone master with byte addresses and 32-bit data
package pca_pkg;

  // register byte offsets
  localparam logic [7:0] PCA_OFS_POWER_CONTROL = 8'h00;
  localparam logic [7:0] PCA_OFS_SUPPLY_STATUS = 8'h04;
  localparam logic [7:0] PCA_OFS_AUTOWAKE_CONTROL = 8'h08;
  localparam logic [7:0] PCA_OFS_AUTOWAKE_WINDOW = 8'h0c;
  localparam logic [7:0] PCA_OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] PCA_OFS_IRQ_MASK = 8'h14;

  // field positions
  localparam int PCA_THR_LSB = 5;
  localparam int PCA_THR_MSB = 7;
  localparam int PCA_DET_EN_BIT = 4;
  localparam int PCA_STBY_BIT = 1;
  localparam int PCA_BELOW_BIT = 2;
  localparam int PCA_AWU_EN_BIT = 1;
  localparam int PCA_AWU_CLR_BIT = 0;
  localparam int PCA_WIN_MSB = 3;
  localparam int PCA_IRQ_MSB = 2;

  // interrupt status bits
  localparam int PCA_IRQ_WAKE = 0;
  localparam int PCA_IRQ_FELL = 1;
  localparam int PCA_IRQ_ROSE = 2;

  // widths and reset values
  localparam int PCA_THR_W = 3;
  localparam int PCA_WIN_W = 4;
  localparam int PCA_CNT_W = 5;
  localparam int PCA_IRQ_W = 3;
  localparam int PCA_PRESC_W = 16;
  localparam logic [31:0] PCA_RESET_WORD = 32'h0000_0000;

  // low-speed oscillator edges per wake-up count step
  localparam int PCA_LSI_DIVIDE = 60000;

  typedef enum logic [0:0] {
    PCA_BUS_IDLE = 1'b0,
    PCA_BUS_ACK = 1'b1
  } pca_bus_state_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } pca_wb_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] data;
  } pca_wr_t;

  // a write hitting the low byte lane of one register
  function automatic logic pca_lane0_write(input pca_wr_t w, input logic [7:0] ofs);
    pca_lane0_write = w.valid && (w.adr == ofs) && w.sel[0];
  endfunction

endpackage

/* logic/pca_wb_slave.sv */
// pca_wb_slave: classic wishbone slave front end, one wait state per access
// assumes the master holds its request until it sees ack
`timescale 1ns/10ps
module pca_wb_slave
  import pca_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input pca_pkg::pca_wb_req_t wb_req,
  input wire logic [31:0] rd_data,
  output pca_pkg::pca_wr_t wr,
  output logic wb_ack,
  output logic [31:0] wb_dat_o
);
  import pca_pkg::*;

  typedef struct packed {
    pca_bus_state_t state;
    logic ack;
    logic [31:0] dat;
  } pca_slave_st_t;

  pca_slave_st_t st;
  pca_slave_st_t next_st;
  logic accept;

  assign accept = wb_req.cyc && wb_req.stb && (st.state == PCA_BUS_IDLE);

  always_comb
  begin
    next_st = st;
    wr.valid = accept && wb_req.we;
    wr.adr = wb_req.adr;
    wr.sel = wb_req.sel;
    wr.data = wb_req.dat;
    case (st.state)
      PCA_BUS_IDLE:
      begin
        next_st.ack = accept;
        next_st.dat = (accept && !wb_req.we) ? rd_data : PCA_RESET_WORD;
        next_st.state = accept ? PCA_BUS_ACK : PCA_BUS_IDLE;
      end
      PCA_BUS_ACK:
      begin
        next_st.ack = 1'b0;
        next_st.dat = PCA_RESET_WORD;
        next_st.state = PCA_BUS_IDLE;
      end
      default:
      begin
        next_st.ack = 1'b0;
        next_st.dat = PCA_RESET_WORD;
        next_st.state = PCA_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      st <= '{state: PCA_BUS_IDLE, ack: 1'b0, dat: PCA_RESET_WORD};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign wb_ack = st.ack;
  assign wb_dat_o = st.dat;

  AST_ACK_NEXT_CYCLE:
  assert property (@(posedge sys_clk) disable iff (reset)
    (wb_req.cyc && wb_req.stb && !wb_ack) |=> wb_ack ##1 !wb_ack)
  else $error("ack not given exactly one cycle after request");

endmodule // pca_wb_slave

/* logic/pca_awu_timer.sv */
// pca_awu_timer: wake-up prescaler and counter stepped by low-speed oscillator edges
// assumes lsi_level is synchronous to sys_clk and slower than half its rate
`timescale 1ns/10ps
module pca_awu_timer
  import pca_pkg::*;
#(
  parameter int DIVIDE = PCA_LSI_DIVIDE
)
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic enable,
  input wire logic clear,
  input wire logic [PCA_WIN_W-1:0] window,
  input wire logic lsi_level,
  output logic wake,
  output logic [PCA_CNT_W-1:0] count
);
  import pca_pkg::*;

  typedef struct packed {
    logic lsi_prev;
    logic [PCA_PRESC_W-1:0] presc;
    logic [PCA_CNT_W-1:0] count;
    logic wake;
  } pca_timer_st_t;

  localparam logic [PCA_PRESC_W-1:0] PRESC_LAST = PCA_PRESC_W'(DIVIDE - 1);

  pca_timer_st_t st;
  pca_timer_st_t next_st;
  logic [PCA_CNT_W-1:0] target;
  logic [PCA_CNT_W-1:0] stepped;

  // window value plus one
  assign target = {1'b0, window} + PCA_CNT_W'(1);
  assign stepped = st.count + PCA_CNT_W'(1);

  always_comb
  begin
    next_st = st;
    next_st.wake = 1'b0;
    next_st.lsi_prev = lsi_level;
    if (!enable || clear)
    begin
      next_st.presc = '0;
      next_st.count = '0;
    end
    else if (lsi_level && !st.lsi_prev)
    begin
      if (st.presc == PRESC_LAST)
      begin
        next_st.presc = '0;
        if (stepped == target)
        begin
          next_st.count = '0;
          next_st.wake = 1'b1;
        end
        else
        begin
          next_st.count = stepped;
        end
      end
      else
      begin
        next_st.presc = st.presc + PCA_PRESC_W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign wake = st.wake;
  assign count = st.count;

  AST_WAKE_AT_WINDOW:
  assert property (@(posedge sys_clk) disable iff (reset)
    $rose(wake) |-> $past(count) + PCA_CNT_W'(1) == $past(target) && count == '0)
  else $error("wake-up not tied to counter reaching window plus one");

  AST_CLEAR_ZEROES:
  assert property (@(posedge sys_clk) disable iff (reset)
    clear |=> count == '0 && !wake)
  else $error("counter not cleared by clear request");

  AST_STEP_ONLY_ON_DIVIDE:
  assert property (@(posedge sys_clk) disable iff (reset)
    (enable && !clear && count != $past(count)) |-> $past(st.presc) == PRESC_LAST)
  else $error("counter moved without a full prescaler period");

endmodule // pca_awu_timer

/* logic/pca_power_regs.sv */
// pca_power_regs: power control register bank with detector, standby select and auto wake-up
// assumes supply_below_cmp and lsi_level are synchronous to sys_clk
//
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/10ps

// What this block does
// - power control bits 7:5 hold a read/write detector threshold code, reset zero.
// - threshold code zero picks lowest pair; higher codes pick higher pairs.
// - power control bit 4 enables the supply detector; read/write, reset zero.
// - power control bit 1 selects standby when one, sleep when zero.
// - status bit 2 is a read-only detector flag, valid while detector enabled.
// - the flag reads one below the selected threshold, zero above it.
// - auto-wake control bit 1 starts wake-up and enables the slow oscillator.
// - clearing that enable stops everything and clears clear bit, window, counter.
// - writing one to bit 0 clears the counter; hardware drops the bit.
// - the counter steps once per 60000 slow oscillator periods.
// - wake-up fires when the counter equals stored window value plus one.
// - the detector output drives external interrupt line 16.
module pca_power_regs
  import pca_pkg::*;
#(
  parameter int LSI_DIVIDE = PCA_LSI_DIVIDE
)
(
  input wire logic sys_clk,
  input wire logic reset,
  input pca_pkg::pca_wb_req_t wb_req,
  output logic wb_ack,
  output logic [31:0] wb_dat_o,
  input wire logic supply_below_cmp,
  input wire logic lsi_level,
  output logic [pca_pkg::PCA_THR_W-1:0] detector_threshold_sel,
  output logic detector_enable,
  output logic standby_select,
  output logic lsi_enable,
  output logic autowake_wakeup,
  output logic external_interrupt_lines_line16_level,
  output logic irq
);
  import pca_pkg::*;

  typedef struct packed {
    logic [PCA_THR_W-1:0] thr;
    logic det_en;
    logic stby;
    logic awu_en;
    logic awu_clr;
    logic [PCA_WIN_W-1:0] window;
    logic below;
    logic [PCA_IRQ_W-1:0] irq_status;
    logic [PCA_IRQ_W-1:0] irq_mask;
    logic irq;
  } pca_regs_st_t;

  pca_regs_st_t st;
  pca_regs_st_t next_st;
  pca_wr_t wr;
  logic [31:0] rd_data;
  logic wake;
  logic [PCA_CNT_W-1:0] awu_count;
  logic [PCA_IRQ_W-1:0] events;

  pca_wb_slave u_slave (
    .sys_clk(sys_clk),
    .reset(reset),
    .wb_req(wb_req),
    .rd_data(rd_data),
    .wr(wr),
    .wb_ack(wb_ack),
    .wb_dat_o(wb_dat_o)
  );

  pca_awu_timer #(
    .DIVIDE(LSI_DIVIDE)
  ) u_timer (
    .sys_clk(sys_clk),
    .reset(reset),
    .enable(st.awu_en),
    .clear(st.awu_clr),
    .window(st.window),
    .lsi_level(lsi_level),
    .wake(wake),
    .count(awu_count)
  );

  // register read mux, unused bits zero
  always_comb
  begin
    rd_data = PCA_RESET_WORD;
    case (wb_req.adr)
      PCA_OFS_POWER_CONTROL:
      begin
        rd_data[PCA_THR_MSB:PCA_THR_LSB] = st.thr;
        rd_data[PCA_DET_EN_BIT] = st.det_en;
        rd_data[PCA_STBY_BIT] = st.stby;
      end
      PCA_OFS_SUPPLY_STATUS:
      begin
        rd_data[PCA_BELOW_BIT] = st.below;
      end
      PCA_OFS_AUTOWAKE_CONTROL:
      begin
        rd_data[PCA_AWU_EN_BIT] = st.awu_en;
        rd_data[PCA_AWU_CLR_BIT] = st.awu_clr;
      end
      PCA_OFS_AUTOWAKE_WINDOW:
      begin
        rd_data[PCA_WIN_MSB:0] = st.window;
      end
      PCA_OFS_IRQ_STATUS:
      begin
        rd_data[PCA_IRQ_MSB:0] = st.irq_status;
      end
      PCA_OFS_IRQ_MASK:
      begin
        rd_data[PCA_IRQ_MSB:0] = st.irq_mask;
      end
      default:
      begin
        rd_data = PCA_RESET_WORD;
      end
    endcase
  end

  always_comb
  begin
    next_st = st;
    next_st.awu_clr = 1'b0;
    if (pca_lane0_write(wr, PCA_OFS_POWER_CONTROL))
    begin
      next_st.thr = wr.data[PCA_THR_MSB:PCA_THR_LSB];
      next_st.det_en = wr.data[PCA_DET_EN_BIT];
      next_st.stby = wr.data[PCA_STBY_BIT];
    end
    if (pca_lane0_write(wr, PCA_OFS_AUTOWAKE_CONTROL))
    begin
      next_st.awu_en = wr.data[PCA_AWU_EN_BIT];
      next_st.awu_clr = wr.data[PCA_AWU_CLR_BIT];
    end
    if (pca_lane0_write(wr, PCA_OFS_AUTOWAKE_WINDOW))
    begin
      next_st.window = wr.data[PCA_WIN_MSB:0];
    end
    if (!next_st.awu_en)
    begin
      next_st.awu_clr = 1'b0;
      next_st.window = '0;
    end
    // detector flag gated by its enable
    next_st.below = st.det_en && supply_below_cmp;
    events = '0;
    events[PCA_IRQ_WAKE] = wake;
    events[PCA_IRQ_FELL] = next_st.below && !st.below;
    events[PCA_IRQ_ROSE] = st.below && !next_st.below && st.det_en;
    if (pca_lane0_write(wr, PCA_OFS_IRQ_STATUS))
    begin
      next_st.irq_status = st.irq_status & ~wr.data[PCA_IRQ_MSB:0];
    end
    // set wins over a same-cycle clear
    next_st.irq_status = next_st.irq_status | events;
    if (pca_lane0_write(wr, PCA_OFS_IRQ_MASK))
    begin
      next_st.irq_mask = wr.data[PCA_IRQ_MSB:0];
    end
    next_st.irq = |(next_st.irq_status & next_st.irq_mask);
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign detector_threshold_sel = st.thr;
  assign detector_enable = st.det_en;
  assign standby_select = st.stby;
  assign lsi_enable = st.awu_en;
  assign autowake_wakeup = wake;
  assign external_interrupt_lines_line16_level = st.below;
  assign irq = st.irq;

  AST_CTRL_WRITE_LANDS:
  assert property (@(posedge sys_clk) disable iff (reset)
    pca_lane0_write(wr, PCA_OFS_POWER_CONTROL) |=>
      detector_threshold_sel == $past(wr.data[PCA_THR_MSB:PCA_THR_LSB])
      && detector_enable == $past(wr.data[PCA_DET_EN_BIT]))
  else $error("power control write not stored");

  AST_STANDBY_SELECT:
  assert property (@(posedge sys_clk) disable iff (reset)
    !pca_lane0_write(wr, PCA_OFS_POWER_CONTROL) |=> $stable(standby_select))
  else $error("standby select changed without a write");

  AST_FLAG_GATED:
  assert property (@(posedge sys_clk) disable iff (reset)
    !detector_enable ##1 !detector_enable |-> !external_interrupt_lines_line16_level)
  else $error("detector flag set while detector disabled");

  AST_FLAG_FOLLOWS_CMP:
  assert property (@(posedge sys_clk) disable iff (reset)
    detector_enable |=> external_interrupt_lines_line16_level == $past(supply_below_cmp))
  else $error("detector flag does not follow comparator");

  AST_AWU_OFF_CLEARS:
  assert property (@(posedge sys_clk) disable iff (reset)
    !lsi_enable |-> st.window == '0 && !st.awu_clr ##1 awu_count == '0)
  else $error("wake-up state not cleared while disabled");

  AST_CLR_SELF_CLEARS:
  assert property (@(posedge sys_clk) disable iff (reset)
    st.awu_clr |=> !st.awu_clr || $past(pca_lane0_write(wr, PCA_OFS_AUTOWAKE_CONTROL)))
  else $error("counter clear bit did not drop");

  AST_RESERVED_ZERO:
  assert property (@(posedge sys_clk) disable iff (reset)
    wb_ack |-> wb_dat_o[31:8] == 24'h00_0000)
  else $error("reserved read bits not zero");

  AST_IRQ_LEVEL:
  assert property (@(posedge sys_clk) disable iff (reset)
    irq == |(st.irq_status & st.irq_mask))
  else $error("interrupt output does not match masked status");

  AST_WAKE_STICKY:
  assert property (@(posedge sys_clk) disable iff (reset)
    wake |=> st.irq_status[PCA_IRQ_WAKE])
  else $error("wake-up event lost from status");

endmodule // pca_power_regs

/* bench/pca_power_regs_test.sv */
// pca_power_regs_test: self-checking bench for the power control register bank
// assumes logic/pca_pkg.sv and the design files are compiled first
`timescale 1ns/10ps
module pca_power_regs_test;
  import pca_pkg::*;
  logic sys_clk;
  logic reset;
  pca_wb_req_t wb_req;
  logic wb_ack;
  logic [31:0] wb_dat_o;
  logic supply_below_cmp;
  logic lsi_level;
  logic [PCA_THR_W-1:0] detector_threshold_sel;
  logic detector_enable;
  logic standby_select;
  logic lsi_enable;
  logic autowake_wakeup;
  logic external_interrupt_lines_line16_level;
  logic irq;
  logic lsi_run;
  logic [31:0] q;
  int fails;
  int tests_run;
  int rises;
  int wakes;
  int wake_rises;
  int start;
  int lsi_div;

  pca_power_regs #(.LSI_DIVIDE(4)) dut_u (
    .sys_clk(sys_clk),
    .reset(reset),
    .wb_req(wb_req),
    .wb_ack(wb_ack),
    .wb_dat_o(wb_dat_o),
    .supply_below_cmp(supply_below_cmp),
    .lsi_level(lsi_level),
    .detector_threshold_sel(detector_threshold_sel),
    .detector_enable(detector_enable),
    .standby_select(standby_select),
    .lsi_enable(lsi_enable),
    .autowake_wakeup(autowake_wakeup),
    .external_interrupt_lines_line16_level(external_interrupt_lines_line16_level),
    .irq(irq)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // slow oscillator, one rise every six clocks; wake-ups counted
  always @(posedge sys_clk)
  begin
    if (lsi_run && lsi_div == 2)
    begin
      lsi_div <= 0;
      lsi_level <= ~lsi_level;
      if (lsi_level == 1'b0) rises <= rises + 1;
    end
    else if (lsi_run) lsi_div <= lsi_div + 1;
    if (autowake_wakeup === 1'b1)
    begin
      wakes <= wakes + 1;
      wake_rises <= rises;
    end
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one classic wishbone cycle; read data left in q
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: d};
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (wb_ack !== 1'b1 && n < 50);
    if (n >= 50) fails++;
    q = wb_dat_o;
    wb_req <= '0;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    check(q, exp);
  endtask

  task wait_wake();
    int w0;
    int n;
    w0 = wakes;
    n = 0;
    while (wakes == w0 && n < 300)
    begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 300) fails++;
  endtask

  task summarize();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    repeat (5000) @(posedge sys_clk);
    fails++;
    summarize();
  end

  initial
  begin
    reset = 1'b1;
    wb_req = '0;
    supply_below_cmp = 1'b0;
    lsi_level = 1'b0;
    lsi_run = 1'b0;
    lsi_div = 0;
    fails = 0;
    tests_run = 0;
    rises = 0;
    wakes = 0;
    wake_rises = 0;
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    for (int i = 0; i < 6; i++) rd(8'(4 * i), 32'h0);
    rd(8'h20, 32'h0);
    wb(1'b1, 8'h00, 32'hffff_ffff);
    rd(8'h00, 32'h0000_00f2);
    check(32'(standby_select), 32'h1);
    check(32'(detector_enable), 32'h1);
    for (int c = 0; c < 8; c++)
    begin
      wb(1'b1, 8'h00, 32'(c * 32 + 16));
      check(32'(detector_threshold_sel), 32'(c));
      rd(8'h00, 32'(c * 32 + 16));
    end
    // detector flag, events and interrupt
    wb(1'b1, 8'h14, 32'h2);
    supply_below_cmp <= 1'b1;
    rd(8'h04, 32'h4);
    check(32'(external_interrupt_lines_line16_level), 32'h1);
    check(32'(irq), 32'h1);
    rd(8'h10, 32'h2);
    wb(1'b1, 8'h04, 32'h0);
    rd(8'h04, 32'h4);
    wb(1'b1, 8'h10, 32'h2);
    rd(8'h10, 32'h0);
    check(32'(irq), 32'h0);
    wb(1'b1, 8'h14, 32'h0);
    supply_below_cmp <= 1'b0;
    rd(8'h04, 32'h0);
    check(32'(external_interrupt_lines_line16_level), 32'h0);
    rd(8'h10, 32'h4);
    check(32'(irq), 32'h0);
    wb(1'b1, 8'h10, 32'h4);
    wb(1'b1, 8'h00, 32'h0);
    check(32'(detector_enable), 32'h0);
    check(32'(standby_select), 32'h0);
    supply_below_cmp <= 1'b1;
    rd(8'h04, 32'h0);
    check(32'(external_interrupt_lines_line16_level), 32'h0);
    // automatic wake-up
    wb(1'b1, 8'h08, 32'h2);
    check(32'(lsi_enable), 32'h1);
    wb(1'b1, 8'h0c, 32'h1);
    rd(8'h0c, 32'h1);
    start = rises;
    lsi_run <= 1'b1;
    wait_wake();
    check(32'(wake_rises - start), 32'h8);
    start = wake_rises;
    wait_wake();
    check(32'(wake_rises - start), 32'h8);
    while (rises < wake_rises + 3) @(posedge sys_clk);
    lsi_run <= 1'b0;
    wb(1'b1, 8'h08, 32'h3);
    rd(8'h08, 32'h2);
    start = rises;
    lsi_run <= 1'b1;
    wait_wake();
    check(32'(wake_rises - start), 32'h8);
    rd(8'h10, 32'h1);
    wb(1'b1, 8'h08, 32'h0);
    check(32'(lsi_enable), 32'h0);
    rd(8'h0c, 32'h0);
    wb(1'b1, 8'h0c, 32'h5);
    rd(8'h0c, 32'h0);
    start = wakes;
    repeat (100) @(posedge sys_clk);
    check(32'(wakes - start), 32'h0);
    summarize();
  end
endmodule // pca_power_regs_test
